// >>> hdl/buck_seq.sv
// Purpose: Switch timing, dead time, bootstrap wake and soft-start control of a buck converter.
// Assumes: All inputs except rst_n are synchronous to core_clk; analog comparators feed stage_in.
// Notes: Registers sit on an Avalon-MM slave with one wait state.
// What this block does
// - Each switching clock edge not skipped by foldback turns the high side on until duty, limit or current ends.
// - Switching clock comes from the oscillator, or the sync input while it toggles.
// - Nonsynchronous mode pulses the bootstrap wake switch every fourth off-time.
// - Current limit turns the high side off until the next clock edge.
// - Synchronous mode waits 25 ns after high side off before low side drive.
// - After a synchronous off-time, the high side stays off until the low side gate is seen discharged.
// - Low side drive waits until the high side gate is seen discharged.
// - Synchronous mode keeps the low side driven for the rest of each off-time.
// - Enable is active high; low enable turns the high side off.
// - A rising enable starts the soft-start ramp from zero.
// - Low enable forces the output ready flag low.
// - The converter stays off while the supply lockout reports low input.
// - Supply good or enable rise ramps the reference up in 64 steps.
// - Turn-off ramps the reference down to zero gradually.
// - Soft-start and soft-stop each take 4096 oscillator cycles.
// - Current limit folds the switching rate back to one quarter.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
module buck_seq (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic enable_in,
    input wire logic supply_lockout,
    input wire logic sync_in,
    input wire logic vout_ok,
    input wire buck_pkg::stage_in_t stage_in,
    output buck_pkg::stage_out_t stage_out,
    output logic output_ok_flag,
    output logic irq
);
    import buck_pkg::*;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    logic [1:0] rst_pipe;
    logic rst_s_n;
    logic [1:0] ctrl_reg;
    logic [15:0] osc_period_reg;
    logic [15:0] max_on_reg;
    logic [IRQ_W-1:0] int_status_reg;
    logic [IRQ_W-1:0] int_enable_reg;
    logic ack_reg;
    logic [31:0] rd_mux;
    logic wr_take;
    logic [15:0] osc_cnt;
    logic osc_tick;
    logic sync_prev_reg;
    logic sync_rise;
    logic [16:0] sync_timer;
    logic ext_active_reg;
    logic sync_lost;
    logic sw_tick;
    logic run;
    logic sync_mode;
    logic fold_reg;
    logic [1:0] fold_cnt;
    logic start_ok;
    logic [1:0] boot_cnt;
    logic [4:0] boot_tmr;
    logic boot_start;
    sw_state_t state_reg;
    sw_state_t state_next;
    logic [15:0] on_cnt;
    logic [3:0] dead_cnt;
    logic dead_done;
    logic end_pulse;
    logic supply_prev_reg;
    logic full_prev_reg;
    logic [IRQ_W-1:0] events;
    logic [6:0] ramp_reference;
    logic ramp_full;

    // The async reset only clears the pipe; release is taken in step with the clock.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_s_n = rst_pipe[1];

    assign sync_mode = ctrl_reg[CTRL_SYNC_BIT];
    assign run = enable_in && supply_lockout;

    // Register bus: every access takes one wait state.
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign wr_take = avs_write && ack_reg;

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            OFF_CTRL: rd_mux = {30'h0, ctrl_reg};
            OFF_OSC_PERIOD: rd_mux = {16'h0000, osc_period_reg};
            OFF_MAX_ON: rd_mux = {16'h0000, max_on_reg};
            OFF_STATUS: rd_mux = {17'h0, ramp_reference, 2'h0, output_ok_flag, fold_reg,
                                  ext_active_reg, ramp_full, run, stage_out.hs_on};
            OFF_INT_STATUS: rd_mux = {28'h0, int_status_reg};
            OFF_INT_ENABLE: rd_mux = {28'h0, int_enable_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ctrl_reg <= CTRL_RST;
            osc_period_reg <= OSC_PERIOD_RST;
            max_on_reg <= MAX_ON_RST;
            int_enable_reg <= 4'h0;
        end else if (wr_take) begin
            if (avs_address == OFF_CTRL && avs_byteenable[0]) begin
                ctrl_reg <= avs_writedata[1:0];
            end
            if (avs_address == OFF_OSC_PERIOD) begin
                osc_period_reg <= merge16(osc_period_reg, avs_writedata, avs_byteenable);
            end
            if (avs_address == OFF_MAX_ON) begin
                max_on_reg <= merge16(max_on_reg, avs_writedata, avs_byteenable);
            end
            if (avs_address == OFF_INT_ENABLE && avs_byteenable[0]) begin
                int_enable_reg <= avs_writedata[IRQ_W-1:0];
            end
        end
    end

    // Internal oscillator; >= keeps it running if the period is shortened mid-count.
    assign osc_tick = (osc_cnt >= 16'(osc_period_reg - 16'h0001));

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            osc_cnt <= 16'h0000;
        end else if (osc_tick) begin
            osc_cnt <= 16'h0000;
        end else begin
            osc_cnt <= 16'(osc_cnt + 16'h0001);
        end
    end

    // External sync takes over on its rising edges and is dropped after two silent periods.
    assign sync_rise = sync_in && !sync_prev_reg;
    assign sync_lost = ext_active_reg && (sync_timer >= {osc_period_reg, 1'b0});
    assign sw_tick = ext_active_reg ? sync_rise : osc_tick;

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            sync_prev_reg <= 1'b0;
            sync_timer <= 17'h00000;
            ext_active_reg <= 1'b0;
        end else begin
            sync_prev_reg <= sync_in;
            sync_timer <= sync_rise ? 17'h00000 : 17'(sync_timer + 17'h00001);
            if (!ctrl_reg[CTRL_EXT_BIT] || sync_lost) begin
                ext_active_reg <= 1'b0;
            end else if (sync_rise) begin
                ext_active_reg <= 1'b1;
            end
        end
    end

    // Foldback lasts until a pulse ends without hitting the limit.
    assign start_ok = !fold_reg || fold_cnt == 2'h0;

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            fold_reg <= 1'b0;
            fold_cnt <= 2'h0;
        end else begin
            if (state_reg == ST_ON && stage_in.cur_limit) begin
                fold_reg <= 1'b1;
            end else if (state_reg == ST_ON && end_pulse) begin
                fold_reg <= 1'b0;
            end
            if (sw_tick) begin
                fold_cnt <= fold_reg ? 2'(fold_cnt + 2'h1) : 2'h0;
            end
        end
    end

    assign end_pulse = !run || stage_in.cur_limit || stage_in.duty_trip
                     || on_cnt >= 16'(max_on_reg - 16'h0001);
    assign dead_done = dead_cnt >= 4'(BBM_CYCLES - 1);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE, ST_OFF: begin
                if (!run) begin
                    state_next = ST_IDLE;
                end else if (sw_tick && start_ok) begin
                    state_next = (state_reg == ST_OFF && sync_mode) ? ST_LS_OFF : ST_ON;
                end
            end
            ST_LS_OFF: begin
                if (!run) begin
                    state_next = ST_IDLE;
                end else if (stage_in.low_side_gate_level) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (end_pulse) begin
                    state_next = sync_mode ? ST_DEAD : ST_OFF;
                end
            end
            ST_DEAD: begin
                if (!run) begin
                    state_next = ST_IDLE;
                end else if (dead_done && stage_in.hs_gate_low) begin
                    state_next = ST_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_reg <= ST_IDLE;
            on_cnt <= 16'h0000;
            dead_cnt <= 4'h0;
        end else begin
            state_reg <= state_next;
            on_cnt <= (state_next == ST_ON) ? 16'(on_cnt + 16'h0001) : 16'h0000;
            dead_cnt <= (state_reg == ST_DEAD && !dead_done) ? 4'(dead_cnt + 4'h1) :
                        (state_reg == ST_DEAD) ? dead_cnt : 4'h0;
        end
    end
    // on_cnt counts ON cycles including the current one, so it restarts at 1 when ON is entered.

    assign boot_start = state_reg == ST_ON && state_next == ST_OFF && !sync_mode && boot_cnt == 2'h0;

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            boot_cnt <= 2'h0;
            boot_tmr <= 5'h00;
        end else begin
            if (state_reg == ST_ON && state_next == ST_OFF && !sync_mode) begin
                boot_cnt <= 2'(boot_cnt + 2'h1);
            end
            if (boot_start) begin
                boot_tmr <= BOOT_PULSE_CYCLES;
            end else if (state_next != ST_OFF) begin
                boot_tmr <= 5'h00;
            end else if (boot_tmr != 5'h00) begin
                boot_tmr <= 5'(boot_tmr - 5'h01);
            end
        end
    end

    // Outputs follow the next state so a current limit drops the switch one edge later.
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            stage_out <= '0;
        end else begin
            stage_out.hs_on <= state_next == ST_ON;
            stage_out.low_side_drive <= state_next == ST_OFF && sync_mode;
            stage_out.boot_wake <= boot_start || (boot_tmr > 5'h01 && state_next == ST_OFF);
        end
    end

    soft_ramp u_ramp (
        .core_clk(core_clk),
        .rst_n(rst_s_n),
        .osc_tick(osc_tick),
        .run(run),
        .ramp_reference(ramp_reference),
        .ramp_full(ramp_full)
    );

    // Interrupt flags: a new event wins over a clear in the same cycle.
    assign events[IRQ_ILIM] = state_reg == ST_ON && stage_in.cur_limit;
    assign events[IRQ_LOCKOUT] = supply_prev_reg && !supply_lockout;
    assign events[IRQ_SS_DONE] = ramp_full && !full_prev_reg;
    assign events[IRQ_SYNC_LOST] = sync_lost;

    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            supply_prev_reg <= 1'b0;
            full_prev_reg <= 1'b0;
            int_status_reg <= 4'h0;
            output_ok_flag <= 1'b0;
        end else begin
            supply_prev_reg <= supply_lockout;
            full_prev_reg <= ramp_full;
            if (wr_take && avs_address == OFF_INT_CLEAR && avs_byteenable[0]) begin
                int_status_reg <= (int_status_reg & ~avs_writedata[IRQ_W-1:0]) | events;
            end else begin
                int_status_reg <= int_status_reg | events;
            end
            output_ok_flag <= enable_in && run && ramp_full && vout_ok;
        end
    end

    assign irq = |(int_status_reg & int_enable_reg);

    sequence s_hs_fall_sync;
        $fell(stage_out.hs_on) && sync_mode;
    endsequence

    sequence s_idle_start;
        state_reg == ST_IDLE && run && sw_tick && start_ok;
    endsequence

    hs_start_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        s_idle_start |=> stage_out.hs_on)
        else $error("High side did not turn on at a clock edge.");

    ilim_off_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        (state_reg == ST_ON && stage_in.cur_limit) |=> !stage_out.hs_on ##1 !stage_out.hs_on)
        else $error("High side stayed on after current limit.");

    dead_time_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        s_hs_fall_sync |-> !stage_out.low_side_drive [*5])
        else $error("Low side drive came before the dead time.");

    hs_wait_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        ($rose(stage_out.hs_on) && $past(state_reg == ST_LS_OFF)) |-> $past(stage_in.low_side_gate_level))
        else $error("High side turned on before low side gate discharged.");

    ls_wait_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        $rose(stage_out.low_side_drive) |-> $past(stage_in.hs_gate_low) && !stage_out.hs_on)
        else $error("Low side drive rose before high side gate discharged.");

    boot_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        $rose(stage_out.boot_wake) |-> !sync_mode && !stage_out.hs_on)
        else $error("Bootstrap wake pulse malformed.");

    // A pulse may be cut by the next tick; one that ends inside the off-time must have been high 8 cycles before it fell.
    boot_len_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        ($fell(stage_out.boot_wake) && state_reg == ST_OFF) |-> $past(stage_out.boot_wake, 8))
        else $error("Bootstrap wake pulse ended early inside an off-time.");

    en_low_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        !run |=> !stage_out.hs_on && (enable_in || !output_ok_flag))
        else $error("Converter active while disabled or locked out.");

    fold_skip_a: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        (fold_reg && fold_cnt != 2'h0 && sw_tick && (state_reg == ST_IDLE || state_reg == ST_OFF))
        |=> !stage_out.hs_on)
        else $error("Pulse started during foldback skip cycle.");
endmodule : buck_seq

// >>> hdl/buck_pkg.sv
// Purpose: Shared constants, carriers and states of the buck sequencing core.
// Assumes: core_clk at 200 MHz; register offsets are byte addresses.
// Notes: The dead time is kept in ns and converted to cycles here; the boot pulse and ramp are given in cycles.
package buck_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int BBM_NS = 25;
    localparam int BBM_CYCLES = (BBM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_STEPS = 64;
    localparam int RAMP_OSC_CYCLES = 4096;
    localparam int STEP_OSC_CYCLES = RAMP_OSC_CYCLES / RAMP_STEPS;
    localparam int BOOT_EVERY = 4;
    localparam int FOLD_DIV = 4;
    localparam logic [4:0] BOOT_PULSE_CYCLES = 5'h14;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_OSC_PERIOD = 8'h04;
    localparam logic [7:0] OFF_MAX_ON = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_INT_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h14;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h18;

    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [15:0] OSC_PERIOD_RST = 16'h00c8;
    localparam logic [15:0] MAX_ON_RST = 16'h00b4;
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;

    localparam int IRQ_W = 4;
    localparam int IRQ_ILIM = 0;
    localparam int IRQ_LOCKOUT = 1;
    localparam int IRQ_SS_DONE = 2;
    localparam int IRQ_SYNC_LOST = 3;

    typedef struct packed {
        logic duty_trip;
        logic cur_limit;
        logic hs_gate_low;
        logic low_side_gate_level;
    } stage_in_t;

    typedef struct packed {
        logic hs_on;
        logic low_side_drive;
        logic boot_wake;
    } stage_out_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LS_OFF,
        ST_ON,
        ST_DEAD,
        ST_OFF
    } sw_state_t;
endpackage : buck_pkg

// >>> hdl/soft_ramp.sv
// Purpose: Digital soft-start and soft-stop reference ramp.
// Assumes: osc_tick is one cycle per internal oscillator period.
// Notes: A new start always begins from zero.
module soft_ramp (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic osc_tick,
    input wire logic run,
    output logic [6:0] ramp_reference,
    output logic ramp_full
);
    import buck_pkg::*;

    logic [5:0] div_reg;
    logic run_prev_reg;
    logic step;

    assign step = osc_tick && (div_reg == 6'(STEP_OSC_CYCLES - 1));
    assign ramp_full = (ramp_reference == 7'(RAMP_STEPS));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_prev_reg <= 1'b0;
        end else begin
            run_prev_reg <= run;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 6'h00;
        end else if (run && !run_prev_reg) begin
            div_reg <= 6'h00;
        end else if (osc_tick) begin
            div_reg <= 6'(div_reg + 6'h01);
        end
    end

    // Each step is 64 oscillator cycles, so 64 steps span 4096 cycles.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_reference <= 7'h00;
        end else if (run && !run_prev_reg) begin
            ramp_reference <= 7'h00;
        end else if (step && run && !ramp_full) begin
            ramp_reference <= 7'(ramp_reference + 7'h01);
        end else if (step && !run && ramp_reference != 7'h00) begin
            ramp_reference <= 7'(ramp_reference - 7'h01);
        end
    end

    ramp_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($changed(ramp_reference) && !$rose(run_prev_reg)) |-> $past(step))
        else $error("Reference moved off a step boundary.");
endmodule : soft_ramp

// >>> dv/power_stage_model.sv
// Purpose: Behavioural power stage facing the buck sequencer.
// Assumes: A gate discharges two core cycles after its drive falls.
// Notes: Current limit is reported only while the high side conducts.
module power_stage_model (
    input wire logic core_clk,
    input wire buck_pkg::stage_out_t drv,
    input wire logic [7:0] on_len,
    input wire logic limit_now,
    output wire buck_pkg::stage_in_t sense
);
    timeunit 1ns;
    timeprecision 100ps;
    import buck_pkg::*;
    logic [7:0] on_cnt = 8'h00;
    logic [1:0] hs_hist = 2'h0;
    logic [1:0] ls_hist = 2'h0;
    always @(posedge core_clk) begin
        on_cnt <= drv.hs_on ? on_cnt + 8'h01 : 8'h00;
        hs_hist <= {hs_hist[0], drv.hs_on};
        ls_hist <= {ls_hist[0], drv.low_side_drive};
    end
    // Gates read discharged late, so a design that skips the wait is caught.
    assign sense.hs_gate_low = ~|{hs_hist, drv.hs_on};
    assign sense.low_side_gate_level = ~|{ls_hist, drv.low_side_drive};
    assign sense.duty_trip = drv.hs_on && on_cnt >= on_len;
    assign sense.cur_limit = drv.hs_on && limit_now;
endmodule : power_stage_model

// >>> dv/buck_pwm_softstart_sequencer_bench.sv
// Purpose: Self-checking bench for the buck sequencer.
// Assumes: OSC_PERIOD is set to 4 for ramps and 40 for switching windows.
// Notes: Pulse counts allow a small tolerance for window phase.
module buck_pwm_softstart_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import buck_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00, on_len = 8'h04;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, v;
    logic avs_waitrequest, output_ok_flag, irq, enable_in = 1'b0, supply_lockout = 1'b1;
    logic sync_in = 1'b0, vout_ok = 1'b1, limit_now = 1'b0, off_chk = 1'b0, sync_run = 1'b0;
    logic hs_q = 1'b0, ls_q = 1'b0, bw_q = 1'b0, lvl_q = 1'b1, trip_q = 1'b0;
    stage_in_t stage_in;
    stage_out_t stage_out;
    int dead = 0, hs_rise = 0, ls_rise = 0, boot_rise = 0, cyc = 0, sync_cnt = 0, sync_per = 60;
    int fail_count = 0, cmp_count = 0, t0, dh, db, dl;
    logic [7:0] ra [7] = '{OFF_CTRL, OFF_OSC_PERIOD, OFF_MAX_ON, OFF_INT_ENABLE, OFF_INT_STATUS, OFF_INT_CLEAR, 8'h1c};
    logic [31:0] re [7] = '{{30'h0, CTRL_RST}, {16'h0, OSC_PERIOD_RST}, {16'h0, MAX_ON_RST}, 0, 0, 0, 0};

    buck_seq dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enable_in(enable_in),
        .supply_lockout(supply_lockout), .sync_in(sync_in), .vout_ok(vout_ok), .stage_in(stage_in),
        .stage_out(stage_out), .output_ok_flag(output_ok_flag), .irq(irq));
    power_stage_model stage (.core_clk(core_clk), .drv(stage_out), .on_len(on_len),
        .limit_now(limit_now), .sense(stage_in));

    always #2.5 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] near(input int x, input int e, input int tol);
        return 32'(x >= e - tol && x <= e + tol);
    endfunction : near

    function automatic int exp_ref(input int cycles, input int per);
        return cycles / (STEP_OSC_CYCLES * per);
    endfunction : exp_ref

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // Waitrequest and read data are taken at the rising edge, before that edge's updates land.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0, v);
    endtask : rd

    task automatic window(input string name);
        int h, b, l;
        repeat (100) @(posedge core_clk);
        h = hs_rise;
        b = boot_rise;
        l = ls_rise;
        repeat (1600) @(posedge core_clk);
        dh = hs_rise - h;
        db = boot_rise - b;
        dl = ls_rise - l;
        $display("test %s done", name);
    endtask : window

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            fail_count++;
            results();
        end
        hs_q <= stage_out.hs_on;
        ls_q <= stage_out.low_side_drive;
        bw_q <= stage_out.boot_wake;
        lvl_q <= stage_in.low_side_gate_level;
        trip_q <= stage_in.duty_trip | stage_in.cur_limit;
        dead <= stage_out.hs_on ? 0 : dead + 1;
        sync_in <= sync_run && sync_cnt < 10;
        sync_cnt <= (sync_cnt + 1) % sync_per;
        if (stage_out.hs_on && !hs_q) begin
            hs_rise <= hs_rise + 1;
            on_len <= 8'(1 + $urandom % 12);
            check(32'(lvl_q), 32'h1, "high side before low gate discharged");
        end
        if (stage_out.low_side_drive && !ls_q) begin
            ls_rise <= ls_rise + 1;
            check(32'(dead >= BBM_CYCLES && stage_in.hs_gate_low), 32'h1, "break before make");
        end
        if (stage_out.boot_wake && !bw_q)
            boot_rise <= boot_rise + 1;
        if (stage_out.hs_on && (stage_out.low_side_drive || stage_out.boot_wake))
            check(32'h1, 32'h0, "overlap with high side");
        if (trip_q)
            check(32'(stage_out.hs_on), 32'h0, "pulse end");
        if (off_chk)
            check(32'(stage_out.hs_on), 32'h0, "switching while off");
    end

    initial begin
        void'($urandom(32'hda6d42b7));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        wr(8'h1c, 32'hffffffff);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            check(v, re[i], "register reset");
        end
        $display("test registers done");
        wr(OFF_OSC_PERIOD, 32'h4);
        wr(OFF_INT_ENABLE, 32'hf);
        check(32'(output_ok_flag), 32'h0, "ready while disabled");
        // Enable stays high through the whole ramp; the scaled oscillator stands in for the minimum hold.
        enable_in <= 1'b1;
        t0 = cyc;
        repeat (8192) @(posedge core_clk);
        rd(OFF_STATUS);
        check(near(int'(v[14:8]), exp_ref(cyc - t0, 4), 1), 32'h1, "mid ramp");
        do begin
            rd(OFF_STATUS);
        end while (v[2] !== 1'b1 && cyc - t0 < 20000);
        check(near(cyc - t0, RAMP_OSC_CYCLES * 4, STEP_OSC_CYCLES * 4), 32'h1, "ramp length");
        check({25'h0, v[14:8]}, 32'h40, "full reference");
        rd(OFF_INT_STATUS);
        check(v & 32'h4, 32'h4, "start done event");
        check({irq, output_ok_flag}, 32'h3, "irq and ready");
        vout_ok <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(32'(output_ok_flag), 32'h0, "ready follows output level");
        vout_ok <= 1'b1;
        wr(OFF_INT_CLEAR, 32'hf);
        @(posedge core_clk);
        check(32'(irq), 32'h0, "irq cleared");
        $display("test soft start done");
        wr(OFF_OSC_PERIOD, 32'd40);
        window("nonsync");
        check(near(dh, 40, 2), 32'h1, "pulse per cycle");
        check(near(db, 10, 1), 32'h1, "boot every fourth");
        check(dl, 0, "no low side in nonsync");
        limit_now <= 1'b1;
        window("limit");
        check(near(dh, 10, 2), 32'h1, "foldback rate");
        rd(OFF_STATUS);
        check(v & 32'h10, 32'h10, "foldback flag");
        wr(OFF_INT_ENABLE, 32'h0);
        @(posedge core_clk);
        check(32'(irq), 32'h0, "masked irq");
        wr(OFF_INT_ENABLE, 32'hf);
        @(posedge core_clk);
        check(32'(irq), 32'h1, "limit irq");
        limit_now <= 1'b0;
        repeat (200) @(posedge core_clk);
        wr(OFF_INT_CLEAR, 32'h1);
        rd(OFF_INT_STATUS);
        check(v & 32'h1, 32'h0, "limit cleared");
        wr(OFF_CTRL, 32'h3);
        window("synchronous");
        check(near(dh, 40, 2), 32'h1, "sync pulses");
        check(near(dl, dh, 1), 32'h1, "low side each off time");
        check(db, 0, "no boot in sync mode");
        sync_per = 50 + $urandom % 20;
        sync_run <= 1'b1;
        window("external sync");
        check(near(dh, 1600 / sync_per, 2), 32'h1, "follows sync");
        rd(OFF_STATUS);
        check(v & 32'h8, 32'h8, "ext sync active");
        sync_run <= 1'b0;
        repeat (200) @(posedge core_clk);
        rd(OFF_STATUS);
        check(v & 32'h8, 32'h0, "back to oscillator");
        rd(OFF_INT_STATUS);
        check(v & 32'h8, 32'h8, "sync lost event");
        wr(OFF_OSC_PERIOD, 32'h4);
        enable_in <= 1'b0;
        t0 = cyc;
        repeat (3) @(posedge core_clk);
        off_chk <= 1'b1;
        check(32'(output_ok_flag), 32'h0, "ready forced low");
        repeat (8192) @(posedge core_clk);
        rd(OFF_STATUS);
        check(near(int'(v[14:8]), 64 - exp_ref(cyc - t0, 4), 1), 32'h1, "soft stop midway");
        repeat (8400) @(posedge core_clk);
        rd(OFF_STATUS);
        check({25'h0, v[14:8]}, 32'h0, "soft stop end");
        $display("test disable done");
        off_chk <= 1'b0;
        enable_in <= 1'b1;
        repeat (3000) @(posedge core_clk);
        supply_lockout <= 1'b0;
        repeat (3) @(posedge core_clk);
        off_chk <= 1'b1;
        rd(OFF_INT_STATUS);
        check(v & 32'h2, 32'h2, "supply fell event");
        check(32'(output_ok_flag), 32'h0, "not ready in lockout");
        off_chk <= 1'b0;
        supply_lockout <= 1'b1;
        t0 = cyc;
        repeat (300) @(posedge core_clk);
        rd(OFF_STATUS);
        check(near(int'(v[14:8]), exp_ref(cyc - t0, 4), 1), 32'h1, "restart from zero");
        $display("test lockout done");
        results();
    end
endmodule : buck_pwm_softstart_sequencer_bench
